// ### src/capability_status_register_bank.sv
`timescale 1ns/10ps
// How it works
// - Identity word: part id high, maker low.
// - Part revision word fixed at build.
// - Assembly id high, assembly maker low.
// - Assembly revision plus bounded feature pointer.
// - Bridge, memory from build; processor, switch zero.
// - Suppress, critical-flow, large-transport bits read zero.
// - Feature-list-present bit always reads one.
// - Address width capability, legal codes, default 001.
// - Port total in bits 15:8, nonzero.
// - Arrival port number in bits 7:0.
// - Source read zero; writes follow I/O slave.
// - Source doorbell follows receive doorbell build.
// - Source port-write follows maintenance slave; low zero.
// - All atomic bits zero in both words.
// - Destination I/O bits follow maintenance master.
// - Destination doorbell follows transmit doorbell build.
// - Left-out functions force operation bits zero.
// - Read-only address mode, legal codes, default 001.
// - First local base word reads zero.
// - Second base word: bit 31 zero, 30:0 writable.
// - Whole 32-bit words, addresses step by four.
// - Capability words steer no internal function.
module capability_status_register_bank #(
  parameter logic [15:0] PART_IDENT        = 16'h1234, // Arbitrary value.
  parameter logic [15:0] MAKER_IDENT       = 16'h5678, // Arbitrary value.
  parameter logic [31:0] PART_REVISION     = 32'h0000_0001,
  parameter logic [15:0] ASSEMBLY_IDENT    = 16'h9abc, // Arbitrary value.
  parameter logic [15:0] ASSEMBLY_MAKER    = 16'hdef0, // Arbitrary value.
  parameter logic [15:0] ASSEMBLY_REVISION = 16'h0001,
  parameter logic [15:0] FEATURE_POINTER   = 16'h0100,
  parameter logic        BRIDGE_PRESENT    = 1'b0,
  parameter logic        MEMORY_PRESENT    = 1'b1,
  parameter logic [2:0]  ADDR_WIDTH_CAP    = 3'h1,
  parameter logic [7:0]  PORT_TOTAL        = 8'h01,
  parameter logic        IO_SLAVE_BUILT    = 1'b1,
  parameter logic        MAINT_SLAVE_BUILT = 1'b1,
  parameter logic        MAINT_MASTER_BUILT= 1'b1,
  parameter logic        MESSAGE_BUILT     = 1'b0,
  parameter logic        MESSAGE_SOURCE    = 1'b0,
  parameter logic        MESSAGE_TARGET    = 1'b0,
  parameter logic        DOORBELL_RX_BUILT = 1'b0,
  parameter logic        DOORBELL_TX_BUILT = 1'b0,
  parameter logic [2:0]  ADDRESS_MODE      = 3'h1
) (
  input  wire logic                                   core_clk,       // System clock.
  input  wire logic                                   reset,          // Sync, active high.
  input  wire capability_status_pkg::maint_req_t      maint_req,      // Slave request.
  input  wire logic [7:0]                             arrival_port,   // Port of the access.
  output capability_status_pkg::maint_rsp_t           maint_rsp,      // Slave answer.
  output logic [30:0]                                 local_cfg_base  // Base address 34:4.
);

  // ---------------------------------------------------------------------------
  // Build-time checks
  // ---------------------------------------------------------------------------
  // A generated core could carry an illegal code; falling back to the minimum
  // keeps software from being told about widths the logic cannot handle.
  function automatic logic [2:0] legal_cap(input logic [2:0] code);
    case (code)
      capability_status_pkg::ADDR_CAP_66_50_34,
      capability_status_pkg::ADDR_CAP_66_34,
      capability_status_pkg::ADDR_CAP_50_34,
      capability_status_pkg::ADDR_CAP_34: legal_cap = code;
      default:                            legal_cap = capability_status_pkg::ADDR_CAP_34;
    endcase
  endfunction

  function automatic logic [2:0] legal_mode(input logic [2:0] code);
    case (code)
      capability_status_pkg::ADDR_MODE_66,
      capability_status_pkg::ADDR_MODE_50,
      capability_status_pkg::ADDR_MODE_34: legal_mode = code;
      default:                             legal_mode = capability_status_pkg::ADDR_MODE_34;
    endcase
  endfunction

  function automatic logic [15:0] legal_ptr(input logic [15:0] ptr);
    if (ptr < capability_status_pkg::FEATURE_PTR_MIN) begin
      legal_ptr = capability_status_pkg::FEATURE_PTR_MIN;
    end else if (ptr > capability_status_pkg::FEATURE_PTR_MAX) begin
      legal_ptr = capability_status_pkg::FEATURE_PTR_MAX;
    end else begin
      legal_ptr = {ptr[15:2], 2'h0};
    end
  endfunction

  // Builds one operations word; each function that is not built clears its bits.
  function automatic logic [31:0] ops_word(
    input logic rd,
    input logic wr,
    input logic msg,
    input logic bell,
    input logic pw
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    w[capability_status_pkg::OPS_READ_BIT]       = rd;
    w[capability_status_pkg::OPS_WRITE_BIT]      = wr;
    w[capability_status_pkg::OPS_SWRITE_BIT]     = wr;
    w[capability_status_pkg::OPS_NWRITE_R_BIT]   = wr;
    w[capability_status_pkg::OPS_MESSAGE_BIT]    = msg;
    w[capability_status_pkg::OPS_DOORBELL_BIT]   = bell;
    w[capability_status_pkg::OPS_PORT_WRITE_BIT] = pw;
    ops_word = w;
  endfunction

  // ---------------------------------------------------------------------------
  // Fixed capability words
  // ---------------------------------------------------------------------------
  // These words only inform software; no logic in the core reads them.
  logic [31:0] part_identity_word;
  logic [31:0] part_revision_word;
  logic [31:0] assembly_identity_word;
  logic [31:0] assembly_revision_pointer;
  logic [31:0] element_feature_flags;
  logic [31:0] source_ops_support;
  logic [31:0] destination_ops_support;
  logic [31:0] logical_layer_control;
  logic [31:0] local_config_base_low;
  logic [15:0] part_ident_field;
  logic [15:0] maker_ident_field;
  logic [31:0] part_revision_field;
  logic [15:0] assembly_ident_field;
  logic [15:0] assembly_maker_field;
  logic [15:0] assembly_revision_field;
  logic [15:0] first_feature_block_pointer;
  logic [2:0]  address_width_capability;
  logic [2:0]  address_mode_select;
  logic [7:0]  port_total_field;

  assign part_ident_field            = PART_IDENT;
  assign maker_ident_field           = MAKER_IDENT;
  assign part_revision_field         = PART_REVISION;
  assign assembly_ident_field        = ASSEMBLY_IDENT;
  assign assembly_maker_field        = ASSEMBLY_MAKER;
  assign assembly_revision_field     = ASSEMBLY_REVISION;
  assign first_feature_block_pointer = legal_ptr(FEATURE_POINTER);
  assign address_width_capability    = legal_cap(ADDR_WIDTH_CAP);
  assign address_mode_select         = legal_mode(ADDRESS_MODE);
  // A zero port total is reserved, so one port is reported instead.
  assign port_total_field            = (PORT_TOTAL == 8'h00) ? 8'h01 : PORT_TOTAL;

  assign part_identity_word        = {part_ident_field, maker_ident_field};
  assign part_revision_word        = part_revision_field;
  assign assembly_identity_word    = {assembly_ident_field, assembly_maker_field};
  assign assembly_revision_pointer = {assembly_revision_field,
                                      first_feature_block_pointer};

  always_comb begin
    element_feature_flags = 32'h0000_0000;
    element_feature_flags[capability_status_pkg::FEAT_BRIDGE_BIT] = BRIDGE_PRESENT;
    element_feature_flags[capability_status_pkg::FEAT_MEMORY_BIT] = MEMORY_PRESENT;
    element_feature_flags[capability_status_pkg::FEAT_PROCESSOR_BIT] = 1'b0;
    element_feature_flags[capability_status_pkg::FEAT_SWITCH_BIT]    = 1'b0;
    element_feature_flags[capability_status_pkg::FEAT_SUPPRESS_BIT]  = 1'b0;
    element_feature_flags[capability_status_pkg::FEAT_CRF_BIT]       = 1'b0;
    element_feature_flags[capability_status_pkg::FEAT_LARGE_BIT]     = 1'b0;
    element_feature_flags[capability_status_pkg::FEAT_EXT_LIST_BIT]  = 1'b1;
    element_feature_flags[2:0] = address_width_capability;
  end

  // Source side: read is never offered; message bits need the message layer.
  assign source_ops_support = ops_word(
    1'b0,
    IO_SLAVE_BUILT,
    MESSAGE_BUILT & MESSAGE_SOURCE,
    DOORBELL_RX_BUILT,
    MAINT_SLAVE_BUILT
  );

  assign destination_ops_support = ops_word(
    MAINT_MASTER_BUILT,
    MAINT_MASTER_BUILT,
    MESSAGE_BUILT & MESSAGE_TARGET,
    DOORBELL_TX_BUILT,
    MAINT_MASTER_BUILT
  );

  assign logical_layer_control = {29'h0000_0000, address_mode_select};
  assign local_config_base_low = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  // Only whole words exist, so the two low address bits take no part.
  function automatic logic hits(
    input logic [capability_status_pkg::ADDR_W-1:0] addr,
    input logic [capability_status_pkg::ADDR_W-1:0] ofs
  );
    hits = (addr[capability_status_pkg::ADDR_W-1:2] ==
            ofs[capability_status_pkg::ADDR_W-1:2]);
  endfunction

  logic hit_base_high;
  assign hit_base_high = hits(maint_req.address, capability_status_pkg::OFS_LOCAL_CFG_BASE_HI);

  // ---------------------------------------------------------------------------
  // Writable base address
  // ---------------------------------------------------------------------------
  logic [30:0] local_cfg_base_field_q;
  logic [30:0] local_cfg_base_field_d;

  // Any other write address, or the read-only bit 31, is dropped silently.
  always_comb begin
    local_cfg_base_field_d = local_cfg_base_field_q;
    if (maint_req.write && hit_base_high) begin
      local_cfg_base_field_d = maint_req.writedata[capability_status_pkg::LCSB_HI_MSB:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      local_cfg_base_field_q <= capability_status_pkg::LCSB_HI_RESET;
    end else begin
      local_cfg_base_field_q <= local_cfg_base_field_d;
    end
  end

  // The registered output equals the register, so it needs no extra flop.
  assign local_cfg_base = local_cfg_base_field_q;

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  logic [31:0] read_mux;
  logic [31:0] port_count_info;

  // Arrival port comes from the maintenance path in the same clock domain.
  assign port_count_info = {16'h0000, port_total_field, arrival_port};

  always_comb begin
    read_mux = 32'h0000_0000;
    if (hits(maint_req.address, capability_status_pkg::OFS_PART_IDENTITY)) begin
      read_mux = part_identity_word;
    end else if (hits(maint_req.address, capability_status_pkg::OFS_PART_REVISION)) begin
      read_mux = part_revision_word;
    end else if (hits(maint_req.address, capability_status_pkg::OFS_ASSEMBLY_IDENTITY)) begin
      read_mux = assembly_identity_word;
    end else if (hits(maint_req.address, capability_status_pkg::OFS_ASSEMBLY_REV_PTR)) begin
      read_mux = assembly_revision_pointer;
    end else if (hits(maint_req.address, capability_status_pkg::OFS_ELEMENT_FEATURES)) begin
      read_mux = element_feature_flags;
    end else if (hits(maint_req.address, capability_status_pkg::OFS_PORT_COUNT_INFO)) begin
      read_mux = port_count_info;
    end else if (hits(maint_req.address, capability_status_pkg::OFS_SOURCE_OPS)) begin
      read_mux = source_ops_support;
    end else if (hits(maint_req.address, capability_status_pkg::OFS_DESTINATION_OPS)) begin
      read_mux = destination_ops_support;
    end else if (hits(maint_req.address, capability_status_pkg::OFS_LOGICAL_LAYER_CTRL)) begin
      read_mux = logical_layer_control;
    end else if (hits(maint_req.address, capability_status_pkg::OFS_LOCAL_CFG_BASE_LOW)) begin
      read_mux = local_config_base_low;
    end else if (hit_base_high) begin
      read_mux = {1'b0, local_cfg_base_field_q};
    end
  end

  // ---------------------------------------------------------------------------
  // Answer flops
  // ---------------------------------------------------------------------------
  // Every read is answered one cycle later, so the bank never stalls the
  // master; waitrequest is held only while reset is applied.
  logic        waitrequest_q;
  logic        readdatavalid_q;
  logic [31:0] readdata_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      waitrequest_q <= 1'b1;
    end else begin
      waitrequest_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      readdatavalid_q <= 1'b0;
    end else begin
      readdatavalid_q <= maint_req.read & ~waitrequest_q;
    end
  end

  // Unmapped addresses read as zero rather than faulting, which keeps a
  // remote probe of the map from stalling the maintenance path.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      readdata_q <= capability_status_pkg::READ_DATA_RESET;
    end else if (maint_req.read && !waitrequest_q) begin
      readdata_q <= read_mux;
    end else begin
      readdata_q <= capability_status_pkg::READ_DATA_RESET;
    end
  end

  assign maint_rsp.waitrequest   = waitrequest_q;
  assign maint_rsp.readdatavalid = readdatavalid_q;
  assign maint_rsp.readdata      = readdata_q;

endmodule

// ### src/capability_status_pkg.sv
package capability_status_pkg;

  // ---------------------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 32;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_PART_IDENTITY      = 24'h00_0000;
  localparam logic [ADDR_W-1:0] OFS_PART_REVISION      = 24'h00_0004;
  localparam logic [ADDR_W-1:0] OFS_ASSEMBLY_IDENTITY  = 24'h00_0008;
  localparam logic [ADDR_W-1:0] OFS_ASSEMBLY_REV_PTR   = 24'h00_000c;
  localparam logic [ADDR_W-1:0] OFS_ELEMENT_FEATURES   = 24'h00_0010;
  localparam logic [ADDR_W-1:0] OFS_PORT_COUNT_INFO    = 24'h00_0014;
  localparam logic [ADDR_W-1:0] OFS_SOURCE_OPS         = 24'h00_0018;
  localparam logic [ADDR_W-1:0] OFS_DESTINATION_OPS    = 24'h00_001c;
  localparam logic [ADDR_W-1:0] OFS_LOGICAL_LAYER_CTRL = 24'h00_004c;
  localparam logic [ADDR_W-1:0] OFS_LOCAL_CFG_BASE_LOW = 24'h00_0058;
  localparam logic [ADDR_W-1:0] OFS_LOCAL_CFG_BASE_HI  = 24'h00_005c;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned FEAT_BRIDGE_BIT    = 31;
  localparam int unsigned FEAT_MEMORY_BIT    = 30;
  localparam int unsigned FEAT_PROCESSOR_BIT = 29;
  localparam int unsigned FEAT_SWITCH_BIT    = 28;
  localparam int unsigned FEAT_SUPPRESS_BIT  = 6;
  localparam int unsigned FEAT_CRF_BIT       = 5;
  localparam int unsigned FEAT_LARGE_BIT     = 4;
  localparam int unsigned FEAT_EXT_LIST_BIT  = 3;
  localparam int unsigned OPS_READ_BIT       = 15;
  localparam int unsigned OPS_WRITE_BIT      = 14;
  localparam int unsigned OPS_SWRITE_BIT     = 13;
  localparam int unsigned OPS_NWRITE_R_BIT   = 12;
  localparam int unsigned OPS_MESSAGE_BIT    = 11;
  localparam int unsigned OPS_DOORBELL_BIT   = 10;
  localparam int unsigned OPS_PORT_WRITE_BIT = 2;
  localparam int unsigned LCSB_HI_MSB        = 30;

  // ---------------------------------------------------------------------------
  // Encodings and values after reset
  // ---------------------------------------------------------------------------
  localparam logic [2:0]  ADDR_CAP_66_50_34  = 3'h7;
  localparam logic [2:0]  ADDR_CAP_66_34     = 3'h5;
  localparam logic [2:0]  ADDR_CAP_50_34     = 3'h3;
  localparam logic [2:0]  ADDR_CAP_34        = 3'h1;
  localparam logic [2:0]  ADDR_MODE_66       = 3'h4;
  localparam logic [2:0]  ADDR_MODE_50       = 3'h2;
  localparam logic [2:0]  ADDR_MODE_34       = 3'h1;
  localparam logic [15:0] FEATURE_PTR_MIN    = 16'h0100;
  localparam logic [15:0] FEATURE_PTR_MAX    = 16'hfffc;
  localparam logic [30:0] LCSB_HI_RESET      = 31'h0000_0000;
  localparam logic [31:0] READ_DATA_RESET    = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Bus carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
  } maint_req_t;

  typedef struct packed {
    logic              waitrequest;
    logic              readdatavalid;
    logic [DATA_W-1:0] readdata;
  } maint_rsp_t;

endpackage

// ### dv/capability_status_register_bank_assertions.sv
`timescale 1ns/10ps
module capability_status_register_bank_assertions (
  input wire logic                              core_clk,       // Clock.
  input wire logic                              reset,          // Sync reset.
  input wire capability_status_pkg::maint_req_t maint_req,      // Request.
  input wire logic [7:0]                        arrival_port,   // Access port.
  input wire capability_status_pkg::maint_rsp_t maint_rsp,      // Answer.
  input wire logic [30:0]                       local_cfg_base  // Base address.
);
  // ---------------------------------------------------------------------------
  // Decoded requests
  // ---------------------------------------------------------------------------
  logic [21:0] wa;
  logic        rd_take;
  logic        wr_take;
  assign wa      = maint_req.address[23:2];
  assign rd_take = maint_req.read && !maint_rsp.waitrequest;
  assign wr_take = maint_req.write && !maint_rsp.waitrequest;

  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  a_wait_release: assert property ($past(!reset) |-> !maint_rsp.waitrequest)
    else $error("waitrequest still high after reset");
  a_read_answer: assert property (rd_take |=> maint_rsp.readdatavalid)
    else $error("read not answered next cycle");
  a_valid_cause: assert property (maint_rsp.readdatavalid |-> $past(rd_take))
    else $error("read data valid without a read");
  a_base_write: assert property (wr_take && wa == capability_status_pkg::OFS_LOCAL_CFG_BASE_HI[23:2]
    |=> local_cfg_base == $past(maint_req.writedata[30:0]))
    else $error("base address write lost");
  a_base_hold: assert property (!(wr_take && wa == capability_status_pkg::OFS_LOCAL_CFG_BASE_HI[23:2])
    |=> $stable(local_cfg_base))
    else $error("base address changed without a write");
  a_base_read: assert property (rd_take && wa == capability_status_pkg::OFS_LOCAL_CFG_BASE_HI[23:2]
    |=> maint_rsp.readdata == {1'b0, $past(local_cfg_base)})
    else $error("base address read wrong");
  a_port_number: assert property (rd_take && wa == capability_status_pkg::OFS_PORT_COUNT_INFO[23:2]
    |=> maint_rsp.readdata[31:16] == 16'h0000 && maint_rsp.readdata[15:8] != 8'h00
    && maint_rsp.readdata[7:0] == $past(arrival_port))
    else $error("port information wrong");
  a_feature_fixed: assert property (rd_take && wa == capability_status_pkg::OFS_ELEMENT_FEATURES[23:2]
    |=> maint_rsp.readdata[29:4] == 26'h0 && maint_rsp.readdata[3])
    else $error("fixed feature bits wrong");
  a_atomic_zero: assert property (rd_take && (wa == capability_status_pkg::OFS_SOURCE_OPS[23:2]
    || wa == capability_status_pkg::OFS_DESTINATION_OPS[23:2]) |=> maint_rsp.readdata[9:3] == 7'h00
    && maint_rsp.readdata[1:0] == 2'h0 && maint_rsp.readdata[31:16] == 16'h0)
    else $error("atomic or reserved operation bits set");
  a_source_read: assert property (rd_take && wa == capability_status_pkg::OFS_SOURCE_OPS[23:2]
    |=> !maint_rsp.readdata[15])
    else $error("source read support set");
  a_base_low: assert property (rd_take && wa == capability_status_pkg::OFS_LOCAL_CFG_BASE_LOW[23:2]
    |=> maint_rsp.readdata == 32'h0000_0000)
    else $error("first base word not zero");
  a_mode_legal: assert property (rd_take && wa == capability_status_pkg::OFS_LOGICAL_LAYER_CTRL[23:2]
    |=> maint_rsp.readdata[31:3] == 29'h0 && maint_rsp.readdata[2:0] inside {3'h4, 3'h2, 3'h1})
    else $error("address mode field illegal");
endmodule

bind capability_status_register_bank capability_status_register_bank_assertions
  u_capability_status_register_bank_assertions (
  .core_clk       (core_clk),
  .reset          (reset),
  .maint_req      (maint_req),
  .arrival_port   (arrival_port),
  .maint_rsp      (maint_rsp),
  .local_cfg_base (local_cfg_base)
);

// ### dv/maint_master_model.sv
`timescale 1ns/10ps
module maint_master_model (
  input  wire capability_status_pkg::maint_rsp_t maint_rsp, // Answer.
  input  wire logic                              core_clk,  // Clock.
  output capability_status_pkg::maint_req_t      maint_req  // Request.
);
  initial maint_req = '0;

  // ---------------------------------------------------------------------------
  // One access, the only route to the registers
  // ---------------------------------------------------------------------------
  // Held requests let a read follow a write on the next edge with no gap.
  task automatic access(input logic rd, input logic wr, input logic [23:0] addr,
                        input logic [31:0] wdata, input bit hold,
                        output logic [31:0] rdata, output bit ok);
    int n;
    // An idle bus lets one edge pass first, so a strobe never drops and rises in one step.
    if (!maint_req.read && !maint_req.write) @(negedge core_clk);
    ok = 1'b0;
    maint_req.read = rd;
    maint_req.write = wr;
    maint_req.address = {addr[23:2], 2'h0};
    maint_req.writedata = wdata;
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge core_clk);
      ok = (maint_rsp.waitrequest === 1'b0);
    end
    @(negedge core_clk);
    rdata = (maint_rsp.readdatavalid === 1'b1) ? maint_rsp.readdata : 32'hxxxx_xxxx;
    if (!hold) begin
      // Released lines show a changed pattern, so stale values cannot pass.
      maint_req.read = 1'b0;
      maint_req.write = 1'b0;
      maint_req.address = ~maint_req.address;
      maint_req.writedata = ~maint_req.writedata;
    end
  endtask
endmodule

// ### dv/capability_status_register_bank_bench.sv
`timescale 1ns/10ps
module capability_status_register_bank_bench;
  localparam logic [15:0] P_ID  = 16'h3c5a; // Arbitrary value.
  localparam logic [15:0] M_ID  = 16'h0f1e; // Arbitrary value.
  localparam logic [31:0] P_REV = 32'h0002_0103;
  localparam logic [15:0] A_ID  = 16'h7b21; // Arbitrary value.
  localparam logic [15:0] A_MK  = 16'h4d02; // Arbitrary value.
  localparam logic [15:0] A_REV = 16'h0003;
  localparam logic [15:0] F_PTR = 16'hfffc;
  localparam logic        YES   = 1'b1;
  localparam logic        NO    = 1'b0;

  logic                              core_clk;
  logic                              reset;
  logic [7:0]                        arrival_port;
  capability_status_pkg::maint_req_t maint_req;
  capability_status_pkg::maint_rsp_t maint_rsp;
  capability_status_pkg::maint_rsp_t alt_rsp;
  logic [30:0]                       local_cfg_base;
  logic [30:0]                       alt_base;
  int                                errors;
  int                                comparisons;

  capability_status_register_bank #(.PART_IDENT(P_ID), .MAKER_IDENT(M_ID),
    .PART_REVISION(P_REV), .ASSEMBLY_IDENT(A_ID), .ASSEMBLY_MAKER(A_MK),
    .ASSEMBLY_REVISION(A_REV), .FEATURE_POINTER(F_PTR), .MESSAGE_BUILT(YES),
    .MESSAGE_SOURCE(YES)) u_capability_status_register_bank (
    .core_clk(core_clk), .reset(reset), .maint_req(maint_req), .arrival_port(arrival_port),
    .maint_rsp(maint_rsp), .local_cfg_base(local_cfg_base));

  // Second build with the opposite options, except MESSAGE_SOURCE which is set in both, shares the request lines.
  capability_status_register_bank #(.BRIDGE_PRESENT(YES), .MEMORY_PRESENT(NO),
    .ADDR_WIDTH_CAP(3'h7), .PORT_TOTAL(8'h04), .IO_SLAVE_BUILT(NO), .MAINT_SLAVE_BUILT(NO),
    .MAINT_MASTER_BUILT(NO), .DOORBELL_RX_BUILT(YES), .DOORBELL_TX_BUILT(YES),
    .MESSAGE_SOURCE(YES), .MESSAGE_TARGET(YES),
    .ADDRESS_MODE(3'h4)) u_capability_status_register_bank_alt (
    .core_clk(core_clk), .reset(reset), .maint_req(maint_req), .arrival_port(arrival_port),
    .maint_rsp(alt_rsp), .local_cfg_base(alt_base));

  maint_master_model u_maint_master_model (
    .maint_rsp(maint_rsp), .core_clk(core_clk), .maint_req(maint_req));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rd(input logic [23:0] addr, output logic [31:0] d, output logic [31:0] a);
    bit ok;
    u_maint_master_model.access(1'b1, 1'b0, addr, 32'h0, 1'b0, d, ok);
    a = (alt_rsp.readdatavalid === 1'b1) ? alt_rsp.readdata : 32'hxxxx_xxxx;
    if (!ok) begin
      errors++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [23:0] addr, input logic [31:0] data, input bit hold);
    bit          ok;
    logic [31:0] d;
    u_maint_master_model.access(1'b0, 1'b1, addr, data, hold, d, ok);
    if (!ok) begin
      errors++;
      finish_test();
    end
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic test_identity();
    logic [23:0] o[4] = '{24'h0, 24'h4, 24'h8, 24'hc};
    logic [31:0] e[4] = '{{P_ID, M_ID}, P_REV, {A_ID, A_MK}, {A_REV, F_PTR}};
    logic [31:0] d;
    logic [31:0] a;
    for (int i = 0; i < 4; i++) begin
      rd(o[i], d, a);
      check("identity", d, e[i]);
    end
    $display("test_identity done");
  endtask

  task automatic test_capabilities();
    logic [23:0] o[4] = '{24'h10, 24'h18, 24'h1c, 24'h4c};
    logic [31:0] em[4] = '{32'h4000_0009, 32'h0000_7804, 32'h0000_f004, 32'h1};
    logic [31:0] ea[4] = '{32'h8000_000f, 32'h0000_0400, 32'h0000_0400, 32'h4};
    logic [31:0] d;
    logic [31:0] a;
    for (int i = 0; i < 4; i++) begin
      rd(o[i], d, a);
      check("caps", d, em[i]);
      check("caps_alt", a, ea[i]);
    end
    $display("test_capabilities done");
  endtask

  task automatic test_port_info();
    logic [7:0]  p[3] = '{8'h00, 8'h5a, 8'hff};
    logic [31:0] d;
    logic [31:0] a;
    for (int i = 0; i < 3; i++) begin
      arrival_port = p[i];
      rd(24'h14, d, a);
      check("port", d, {16'h0, 8'h01, p[i]});
      check("port_alt", a, {16'h0, 8'h04, p[i]});
    end
    $display("test_port_info done");
  endtask

  task automatic test_writes();
    logic [23:0] o[5] = '{24'h0, 24'h10, 24'h4c, 24'h58, 24'h40};
    logic [31:0] e[5] = '{{P_ID, M_ID}, 32'h4000_0009, 32'h1, 32'h0, 32'h0};
    logic [31:0] d;
    logic [31:0] a;
    rd(24'h5c, d, a);
    check("base_reset", d, 32'h0);
    wr(24'h5c, 32'hffff_ffff, 1'b1);
    rd(24'h5c, d, a);
    check("base_read", d, 32'h7fff_ffff);
    wr(24'h5c, 32'h8000_1234, 1'b0);
    check("base_pins", {1'b0, local_cfg_base}, 32'h0000_1234);
    check("base_pins_alt", {1'b0, alt_base}, 32'h0000_1234);
    for (int i = 0; i < 5; i++) begin
      wr(o[i], 32'hffff_ffff, 1'b0);
      rd(o[i], d, a);
      check("ro_write", d, e[i]);
    end
    check("base_kept", {1'b0, local_cfg_base}, 32'h0000_1234);
    $display("test_writes done");
  endtask

  initial begin
    errors = 0;
    comparisons = 0;
    reset = 1'b1;
    arrival_port = 8'h00;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    reset = 1'b0;
    @(negedge core_clk);
    test_identity();
    test_capabilities();
    test_port_info();
    test_writes();
    finish_test();
  end
endmodule
